//--- logic/hps_dev.sv
// Device end: dual-slot serial shift and latch interface with direct mode.
// Function
// - Multi-slot: slot B out forwards slot A stream.
// - Single-slot: slot B out shifts slot B status.
// - Mode pin undriven until power good; captured.
// - Reset input drives reset output only serially.
// - Latch edge copies shift into parallel registers.
// - Host makes latch clocks synchronous to bus.
// - Data shifts on rising shift clock edges.
// - Multi-slot shares clocks, latches and resets.
// - Unused LED enables are tied low externally.
// - Slot A out strap picks multi or single.
`timescale 1ns/1ps
`default_nettype none
module hps_dev
  import hps_pkg::*;
#(
  parameter int W = SHIFT_W
)(
  input  wire logic         mclk,             // System clock.
  input  wire logic         rstn,             // Asynchronous reset, active low.
  hps_if.dev                link,             // Pins toward the host.
  input  wire logic [W-1:0] slot_a_status,    // Slot A status to report.
  input  wire logic [W-1:0] slot_b_status,    // Slot B status to report.
  output logic      [W-1:0] slot_a_ctl,       // Slot A parallel control.
  output logic      [W-1:0] slot_b_ctl,       // Slot B parallel control.
  output logic              slot_a_reset_out_n,   // Slot A reset, low active.
  output logic              slot_b_reset_out_n,   // Slot B reset, low active.
  output logic              slot_a_attn_led_out_n, // Slot A attention LED.
  output logic              slot_a_pwr_led_out_n,  // Slot A power LED.
  output logic              slot_b_attn_led_out_n, // Slot B attention LED.
  output logic              slot_b_pwr_led_out_n,  // Slot B power LED.
  output logic              mode_valid,       // A mode has been captured.
  output logic              mode_direct,      // Captured direct mode.
  output logic              mode_multi        // Captured multi-slot mode.
);

  // ==========================================================================
  // Helpers
  // Shift left by one, taking a new bit at the bottom.
  function automatic logic [W-1:0] shl(input logic [W-1:0] v, input logic b);
    shl = {v[W-2:0], b};
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] prev_q;
  wire  [SYNC_W-1:0] rise_w;
  wire               pg_s, cka_s, ckb_s, lta_s, ltb_s, dia_s, dib_s;
  wire               rsa_s, rsb_s, mdb_s, sta_s;
  wire               pg_r, cka_r, ckb_r, lta_r, ltb_r;
  wire  [5:0]        rise_unused_w;

  // Every pin is asynchronous to mclk, so all of them pass two stages.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= {link.supplies_valid, link.clk_a, link.clk_b, link.lat_a,
                 link.lat_b, link.din_a, link.din_b, link.rst_a_n,
                 link.rst_b_n, link.sb_lvl, link.sa_lvl};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Named views of the synchronised pins and their rising edges.
  assign rise_w = sync_q & ~prev_q;
  assign {pg_s, cka_s, ckb_s, lta_s, ltb_s, dia_s, dib_s,
          rsa_s, rsb_s, mdb_s, sta_s} = sync_q;
  assign {pg_r, cka_r, ckb_r, lta_r, ltb_r, rise_unused_w} = rise_w;

  // ==========================================================================
  // Mode capture
  logic valid_q;
  logic direct_q;
  logic multi_q;
  wire  serial_w;
  wire  direct_w;

  // The mode is taken only on the power good rise; later pin activity is
  // ignored because the same pins carry live data once running.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      valid_q  <= 1'b0;
      direct_q <= 1'b0;
      multi_q  <= 1'b0;
    end
    else if (pg_r)
    begin
      valid_q  <= 1'b1;
      direct_q <= mdb_s;
      multi_q  <= sta_s;
    end
    else if (!pg_s)
    begin
      valid_q  <= 1'b0;
    end
  end

  // Active mode decode.
  assign serial_w = pg_s & valid_q & ~direct_q;
  assign direct_w = pg_s & valid_q & direct_q;

  // ==========================================================================
  // Shift and parallel registers
  logic [W-1:0] sh_a_q;
  logic [W-1:0] sh_b_q;
  logic [W-1:0] ctl_a_q;
  logic [W-1:0] ctl_b_q;

  // Command bits enter on shift clock rises and land on latch rises.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_a_q  <= '0;
      sh_b_q  <= '0;
      ctl_a_q <= '0;
      ctl_b_q <= '0;
    end
    else if (pg_r)
    begin
      ctl_a_q <= '0;
      ctl_b_q <= '0;
    end
    else if (serial_w)
    begin
      if (cka_r)
        sh_a_q <= shl(sh_a_q, dia_s);
      if (ckb_r)
        sh_b_q <= shl(sh_b_q, dib_s);
      if (lta_r)
        ctl_a_q <= sh_a_q;
      if (ltb_r)
        ctl_b_q <= sh_b_q;
    end
  end

  // ==========================================================================
  // Serial outputs
  logic [W-1:0] st_a_q;
  logic [W-1:0] st_b_q;
  logic         so_a_q;
  logic         so_b_q;
  logic         drv_n_q;

  // Status is loaded on the latch edge with its top bit already on the pin,
  // so the host reads the first bit at its first shift clock rise.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_a_q <= '0;
      so_a_q <= 1'b0;
    end
    else if (serial_w && lta_r)
    begin
      so_a_q <= slot_a_status[W-1];
      st_a_q <= shl(slot_a_status, 1'b0);
    end
    else if (serial_w && cka_r)
    begin
      so_a_q <= st_a_q[W-1];
      st_a_q <= shl(st_a_q, 1'b0);
    end
  end

  // Slot B out either forwards the bit leaving slot A or reports slot B.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_b_q <= '0;
      so_b_q <= 1'b0;
    end
    else if (serial_w && ltb_r && !multi_q)
    begin
      so_b_q <= slot_b_status[W-1];
      st_b_q <= shl(slot_b_status, 1'b0);
    end
    else if (serial_w && ckb_r)
    begin
      if (multi_q)
        so_b_q <= sh_a_q[W-1];
      else
        so_b_q <= st_b_q[W-1];
      st_b_q <= shl(st_b_q, 1'b0);
    end
  end

  // The serial out pins stay released outside serial operation, which also
  // leaves the mode strap free while power good is low.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      drv_n_q <= 1'b1;
    else
      drv_n_q <= ~serial_w;
  end

  // Pin drive from flops.
  assign link.sa_o    = so_a_q;
  assign link.sb_o    = so_b_q;
  assign link.sa_oe_n = drv_n_q;
  assign link.sb_oe_n = drv_n_q;

  // ==========================================================================
  // Slot outputs
  logic rst_a_q;
  logic rst_b_q;
  logic led_q [4];

  // Reset follows its control pin only in serial mode; direct mode ignores
  // the pin and keeps the slot out of reset.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_a_q <= 1'b1;
      rst_b_q <= 1'b1;
    end
    else
    begin
      rst_a_q <= serial_w ? rsa_s : 1'b1;
      rst_b_q <= serial_w ? rsb_s : 1'b1;
    end
  end

  // LEDs are active low; direct mode reads the shared clock pins as enables.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
        led_q[i] <= 1'b1;
    end
    else
    begin
      led_q[0] <= direct_w ? ~lta_s : ~(serial_w & ctl_a_q[CTL_ATTN]);
      led_q[1] <= direct_w ? ~cka_s : ~(serial_w & ctl_a_q[CTL_PWR]);
      led_q[2] <= direct_w ? ~ltb_s : ~(serial_w & ctl_b_q[CTL_ATTN]);
      led_q[3] <= direct_w ? ~ckb_s : ~(serial_w & ctl_b_q[CTL_PWR]);
    end
  end

  // User side outputs.
  assign slot_a_ctl            = ctl_a_q;
  assign slot_b_ctl            = ctl_b_q;
  assign slot_a_reset_out_n    = rst_a_q;
  assign slot_b_reset_out_n    = rst_b_q;
  assign slot_a_attn_led_out_n = led_q[0];
  assign slot_a_pwr_led_out_n  = led_q[1];
  assign slot_b_attn_led_out_n = led_q[2];
  assign slot_b_pwr_led_out_n  = led_q[3];
  assign mode_valid            = valid_q;
  assign mode_direct           = direct_q;
  assign mode_multi            = multi_q;

endmodule // hps_dev
`default_nettype wire

//--- shared/hps_pkg.sv
// Shared constants and types for the hot-plug slot serial control link.
`default_nettype none
package hps_pkg;
  // ==========================================================================
  // Link shape
  localparam int SHIFT_W        = 8;   // Bits per slot in one frame.
  localparam int FIFO_DEPTH     = 8;   // Command words buffered in the host.
  localparam int SYNC_W         = 11;  // Device pins that cross into mclk.
  // ==========================================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int HALF_CYC       = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  // ==========================================================================
  // Parallel control register fields
  localparam int CTL_ATTN       = 0;   // Attention LED on.
  localparam int CTL_PWR        = 1;   // Power LED on.
  // ==========================================================================
  // Host sequencer states
  typedef enum logic [1:0] {
    HPS_IDLE  = 2'b00,
    HPS_SHIFT = 2'b01,
    HPS_LATCH = 2'b10,
    HPS_DONE  = 2'b11
  } hps_state_e;
endpackage
`default_nettype wire

//--- shared/hps_if.sv
// Pin bundle between the slot controller device and the hot-plug host.
`timescale 1ns/1ps
`default_nettype none
interface hps_if;
  logic clk_a;          // Slot A shift clock, or power LED enable in direct mode.
  logic clk_b;          // Slot B shift clock, or power LED enable in direct mode.
  logic lat_a;          // Slot A latch clock, or attention LED enable in direct mode.
  logic lat_b;          // Slot B latch clock, or attention LED enable in direct mode.
  logic din_a;          // Serial data into slot A.
  logic din_b;          // Serial data into slot B.
  logic rst_a_n;        // Slot A reset control.
  logic rst_b_n;        // Slot B reset control.
  logic supplies_valid; // Power good, driven by the bench.
  logic strap_a;        // Pull level on the slot A serial out pin.
  logic strap_b;        // Pull level on the slot B serial out pin.
  logic sa_o;           // Device drive of the slot A serial out pin.
  logic sa_oe_n;        // Low while the device drives that pin.
  logic sb_o;           // Device drive of the slot B serial out pin.
  logic sb_oe_n;        // Low while the device drives that pin.
  logic sa_lvl;         // Resolved slot A serial out pin level.
  logic sb_lvl;         // Resolved slot B serial out pin level.

  // Undriven pins fall back to their external pull.
  assign sa_lvl = sa_oe_n ? strap_a : sa_o;
  assign sb_lvl = sb_oe_n ? strap_b : sb_o;

  modport dev (
    input  clk_a, clk_b, lat_a, lat_b, din_a, din_b, rst_a_n, rst_b_n,
    input  supplies_valid, sa_lvl, sb_lvl,
    output sa_o, sa_oe_n, sb_o, sb_oe_n
  );
  modport host (
    output clk_a, clk_b, lat_a, lat_b, din_a, din_b, rst_a_n, rst_b_n,
    input  sa_lvl, sb_lvl
  );
endinterface
`default_nettype wire

//--- logic/hps_host.sv
// Host end: command FIFO and serial frame sequencer toward the device.
`timescale 1ns/1ps
`default_nettype none
module hps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)(
  input  wire logic             mclk,      // System clock.
  input  wire logic             rstn,      // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Not full.
  input  wire logic [WIDTH-1:0] in_data,   // Write word.
  output logic                  out_valid, // Not empty.
  input  wire logic             out_ready, // Read acknowledge.
  output logic      [WIDTH-1:0] out_data   // Head word.
);
  localparam int AW = $clog2(DEPTH);
  // The count needs one bit more than the pointers, or a full buffer would read as empty.
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             full_q;
  logic             empty_q;
  wire              push_w;
  wire              pop_w;

  // Handshake decode; count moves only on an unmatched push or pop.
  assign push_w = in_valid & ~full_q;
  assign pop_w  = out_ready & ~empty_q;
  assign cnt_d  = cnt_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      if (push_w)
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop_w)
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q   <= cnt_d;
      full_q  <= (cnt_d == FULL_CNT);
      empty_q <= (cnt_d == '0);
    end
  end

  // Storage carries no reset.
  always_ff @(posedge mclk)
  begin
    if (push_w)
      mem_q[wp_q] <= in_data;
  end

  assign in_ready  = ~full_q;
  assign out_valid = ~empty_q;
  assign out_data  = mem_q[rp_q];
endmodule // hps_fifo

module hps_host
  import hps_pkg::*;
#(
  parameter int W = SHIFT_W
)(
  input  wire logic           mclk,       // System clock, also the bus clock.
  input  wire logic           rstn,       // Asynchronous reset, active low.
  hps_if.host                 link,       // Pins toward the device.
  input  wire logic           cmd_valid,  // Command word offered.
  output logic                cmd_ready,  // FIFO has room.
  input  wire logic [2*W-1:0] cmd_data,   // Upper half slot B, lower slot A.
  output logic                rsp_valid,  // One-cycle status pulse.
  output logic      [2*W-1:0] rsp_data,   // Status read in the frame.
  input  wire logic           rst_ctl_n,  // Slot reset control for both slots.
  input  wire logic           direct_sel, // System runs the device direct.
  input  wire logic [3:0]     led_en      // Direct LED enables, A attn/pwr, B attn/pwr.
);
  localparam int          PH_W = $clog2(2 * HALF_CYC);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF_CYC - 1);
  localparam int          BW   = $clog2(W);
  localparam logic [BW-1:0] BIT_LAST = BW'(W - 1);

  // Shift left by one, taking a new bit at the bottom.
  function automatic logic [W-1:0] shl(input logic [W-1:0] v, input logic b);
    shl = {v[W-2:0], b};
  endfunction

  // ==========================================================================
  // Command buffer
  wire           f_valid;
  wire [2*W-1:0] f_data;
  wire           f_take;
  hps_state_e    state_q;

  // Draining stalls outside idle and in direct mode, so the FIFO fills.
  assign f_take = (state_q == HPS_IDLE) & ~direct_sel & f_valid;

  hps_fifo #(.WIDTH(2 * W), .DEPTH(FIFO_DEPTH)) hps_fifo_i (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd_data),
    .out_valid (f_valid),
    .out_ready (f_take),
    .out_data  (f_data)
  );

  // ==========================================================================
  // Return pin synchronisers
  logic [1:0] meta_q;
  logic [1:0] sync_q;

  // Device outputs change on the device's own timing; two stages each.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {link.sb_lvl, link.sa_lvl};
      sync_q <= meta_q;
    end
  end

  // ==========================================================================
  // Frame sequencer
  logic [PH_W-1:0] ph_q;
  logic [BW-1:0]   bit_q;
  logic [W-1:0]    sha_q, shb_q, rxa_q, rxb_q;
  logic            sclk_q, lat_q, da_q, db_q, rv_q;

  // Data changes at the low phase start, the clock rises mid-period, and the
  // latch rises one half period after the last shift edge, all from mclk.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= HPS_IDLE;
      ph_q    <= '0;
      bit_q   <= '0;
      sha_q   <= '0;
      shb_q   <= '0;
      rxa_q   <= '0;
      rxb_q   <= '0;
      sclk_q  <= 1'b0;
      lat_q   <= 1'b0;
      da_q    <= 1'b0;
      db_q    <= 1'b0;
      rv_q    <= 1'b0;
    end
    else
    begin
      rv_q <= 1'b0;
      case (state_q)
        HPS_IDLE:
        begin
          if (f_take)
          begin
            sha_q   <= f_data[W-1:0];
            shb_q   <= f_data[2*W-1:W];
            ph_q    <= '0;
            bit_q   <= '0;
            state_q <= HPS_SHIFT;
          end
        end
        HPS_SHIFT:
        begin
          ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
          if (ph_q == '0)
          begin
            sclk_q <= 1'b0;
            da_q   <= sha_q[W-1];
            db_q   <= shb_q[W-1];
            sha_q  <= shl(sha_q, 1'b0);
            shb_q  <= shl(shb_q, 1'b0);
          end
          if (ph_q == PH_HALF)
          begin
            sclk_q <= 1'b1;
            rxa_q  <= shl(rxa_q, sync_q[0]);
            rxb_q  <= shl(rxb_q, sync_q[1]);
          end
          if (ph_q == PH_LAST)
          begin
            bit_q <= bit_q + 1'b1;
            if (bit_q == BIT_LAST)
              state_q <= HPS_LATCH;
          end
        end
        HPS_LATCH:
        begin
          ph_q   <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
          sclk_q <= 1'b0;
          lat_q  <= (ph_q < PH_HALF);
          if (ph_q == PH_LAST)
            state_q <= HPS_DONE;
        end
        HPS_DONE:
        begin
          rv_q    <= 1'b1;
          state_q <= HPS_IDLE;
        end
        default:
          state_q <= HPS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive
  logic [7:0] pin_q;

  // One divider feeds both slots so chained slots see identical timing;
  // in direct mode the same pins carry the LED enables instead.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pin_q <= 8'h00;
    else
      pin_q <= direct_sel ? {led_en[1], led_en[3], led_en[0], led_en[2],
                             2'b00, rst_ctl_n, rst_ctl_n}
                          : {sclk_q, sclk_q, lat_q, lat_q,
                             da_q, db_q, rst_ctl_n, rst_ctl_n};
  end

  assign {link.clk_a, link.clk_b, link.lat_a, link.lat_b,
          link.din_a, link.din_b, link.rst_a_n, link.rst_b_n} = pin_q;
  assign rsp_valid = rv_q;
  assign rsp_data  = {rxb_q, rxa_q};

endmodule // hps_host
`default_nettype wire

//--- testbench/hps_asserts.sv
// Concurrent checks on the link pins between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module hps_asserts (
  input wire logic mclk,           // System clock.
  input wire logic rstn,           // Reset, active low.
  input wire logic clk_a,          // Slot A shift clock.
  input wire logic clk_b,          // Slot B shift clock.
  input wire logic lat_a,          // Slot A latch clock.
  input wire logic lat_b,          // Slot B latch clock.
  input wire logic din_a,          // Slot A serial data.
  input wire logic din_b,          // Slot B serial data.
  input wire logic rst_a_n,        // Slot A reset control.
  input wire logic rst_b_n,        // Slot B reset control.
  input wire logic supplies_valid, // Power good.
  input wire logic sb_lvl,         // Resolved slot B out pin.
  input wire logic sa_oe_n,        // Slot A out enable, low drives.
  input wire logic sb_oe_n         // Slot B out enable, low drives.
);
  // ==========================================================================
  // Mode mirror
  logic pg_q;  // Power good one edge ago.
  logic ser_q; // Serial strap seen at the last power good rise.

  // Reset assumes direct, so no pin drive is expected until a capture.
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) pg_q <= 1'h0;
    else pg_q <= supplies_valid;

  // The strap is read at the pin edge; the device lags it by its synchroniser.
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) ser_q <= 1'h0;
    else if (supplies_valid && !pg_q) ser_q <= !sb_lvl;

  // ==========================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_lat_pulse;
    lat_a [*3] ##1 !lat_a;
  endsequence
  sequence s_clk_pulse;
    clk_a [*3] ##1 !clk_a;
  endsequence
  property p_pin_hiz;
    !supplies_valid [*6] |-> sa_oe_n && sb_oe_n;
  endproperty
  property p_dir_hiz;
    !ser_q |-> sa_oe_n && sb_oe_n;
  endproperty
  property p_ser_drive;
    (ser_q && pg_q) ##0 supplies_valid [*8] |-> !sa_oe_n && !sb_oe_n;
  endproperty
  property p_mode_fixed;
    supplies_valid && pg_q && !$past(sb_oe_n) |-> !sb_oe_n;
  endproperty
  property p_shared;
    ser_q |-> clk_a == clk_b && lat_a == lat_b && rst_a_n == rst_b_n;
  endproperty
  property p_clk_width;
    ser_q && $rose(clk_a) |=> s_clk_pulse;
  endproperty
  property p_din_hold;
    ser_q && $rose(clk_a) |-> $stable(din_a) && $stable(din_b);
  endproperty
  property p_lat_width;
    ser_q && $rose(lat_a) |=> s_lat_pulse;
  endproperty
  property p_lat_apart;
    ser_q && lat_a |-> !clk_a;
  endproperty

  a_pin_hiz: assert property (p_pin_hiz)
    else $error("Serial out driven while power good is low.");
  a_dir_hiz: assert property (p_dir_hiz)
    else $error("Serial out driven outside serial mode.");
  a_ser_drive: assert property (p_ser_drive)
    else $error("Serial out not driven in serial mode.");
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("Serial drive dropped while power good held.");
  a_shared: assert property (p_shared)
    else $error("Slot clocks or resets differ.");
  a_clk_width: assert property (p_clk_width)
    else $error("Shift clock high time wrong.");
  a_din_hold: assert property (p_din_hold)
    else $error("Data moved at a shift edge.");
  a_lat_width: assert property (p_lat_width)
    else $error("Latch clock high time wrong.");
  a_lat_apart: assert property (p_lat_apart)
    else $error("Latch overlaps shift clock.");
endmodule // hps_asserts
`default_nettype wire

//--- testbench/hot_plug_slot_serial_ctrl_if_tb.sv
// Self-checking bench: host and device ends joined by the pin bundle.
`timescale 1ns/1ps
`default_nettype none
module hot_plug_slot_serial_ctrl_if_tb;
  logic        mclk;       // System clock.
  logic        rstn;       // Reset, active low.
  logic        cmd_valid;  // Command offered.
  logic        cmd_ready;  // Host buffer has room.
  logic [15:0] cmd_data;   // Slot B and slot A control.
  logic        rsp_valid;  // Frame finished.
  logic [15:0] rsp_data;   // Status read back.
  logic        rst_ctl_n;  // Slot reset control.
  logic        direct_sel; // Host runs direct.
  logic [3:0]  led_en;     // Direct LED enables.
  logic [7:0]  a_ctl;      // Slot A control.
  logic [7:0]  b_ctl;      // Slot B control.
  logic [1:0]  rout_n;     // Slot A and B reset outs.
  logic [3:0]  leds_n;     // B pwr, B attn, A pwr, A attn.
  logic [2:0]  mode;       // Valid, direct, multi.
  logic [15:0] r;          // Last status word.
  int          n_fail;     // Mismatches.
  int          n_compared; // Comparisons.
  int          n;          // Scratch count.

  hps_if link ();

  hps_dev hps_dev_i (
    .mclk(mclk), .rstn(rstn), .link(link), .slot_a_status(8'h5A), .slot_b_status(8'hC3),
    .slot_a_ctl(a_ctl), .slot_b_ctl(b_ctl), .slot_a_reset_out_n(rout_n[1]), .slot_b_reset_out_n(rout_n[0]),
    .slot_a_attn_led_out_n(leds_n[0]), .slot_a_pwr_led_out_n(leds_n[1]), .slot_b_attn_led_out_n(leds_n[2]),
    .slot_b_pwr_led_out_n(leds_n[3]), .mode_valid(mode[2]), .mode_direct(mode[1]), .mode_multi(mode[0])
  );
  hps_host hps_host_i (
    .mclk(mclk), .rstn(rstn), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rst_ctl_n(rst_ctl_n),
    .direct_sel(direct_sel), .led_en(led_en)
  );
  hps_asserts hps_asserts_i (
    .mclk(mclk), .rstn(rstn), .clk_a(link.clk_a), .clk_b(link.clk_b), .lat_a(link.lat_a),
    .lat_b(link.lat_b), .din_a(link.din_a), .din_b(link.din_b), .rst_a_n(link.rst_a_n),
    .rst_b_n(link.rst_b_n), .supplies_valid(link.supplies_valid), .sb_lvl(link.sb_lvl),
    .sa_oe_n(link.sa_oe_n), .sb_oe_n(link.sb_oe_n)
  );

  // ==========================================================================
  // Clock
  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task complete_run;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // Bounded wait on ready (0) or the status pulse (1); a hang ends the run.
  task await(input int sel);
    repeat (300)
    begin
      @(posedge mclk);
      if ((sel == 0 ? cmd_ready : rsp_valid) === 1'h1) return;
    end
    n_fail++;
    complete_run;
  endtask

  // Straps are set well before the power good rise and released after capture.
  task pg_cycle(input logic sa, input logic sb);
    link.supplies_valid <= 1'h0;
    cyc(10);
    link.strap_a <= sa;
    link.strap_b <= sb;
    cyc(4);
    link.supplies_valid <= 1'h1;
    cyc(8);
    link.strap_a <= 1'h0;
    link.strap_b <= 1'h0;
    cyc(4);
  endtask

  task run(input logic [15:0] c);
    cmd_valid <= 1'h1;
    cmd_data <= c;
    await(0);
    cmd_valid <= 1'h0;
    await(1);
    r = rsp_data;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rstn = 1'h0;
    cmd_valid = 1'h0;
    cmd_data = 16'h0;
    rst_ctl_n = 1'h1;
    direct_sel = 1'h0;
    led_en = 4'h0;
    link.supplies_valid = 1'h0;
    link.strap_a = 1'h0;
    link.strap_b = 1'h0;
    cyc(3);
    rstn <= 1'h1;
    // Single slot: control latched, status read one frame later.
    pg_cycle(1'h0, 1'h0);
    chk(16'(mode), 16'h4);
    run(16'h0201);
    chk({b_ctl, a_ctl}, 16'h0201);
    chk(16'(leds_n), 16'h6);
    run(16'h0000);
    chk(r, 16'hC35A);
    rst_ctl_n <= 1'h0;
    cyc(6);
    chk(16'(rout_n), 16'h0);
    rst_ctl_n <= 1'h1;
    cyc(6);
    chk(16'(rout_n), 16'h3);
    // Multi slot: slot B out carries the slot A stream onward. Its output stage adds one bit of delay, so the
    // second frame reads the last slot A bit of the earlier zero frame, then the top seven bits of the first.
    pg_cycle(1'h1, 1'h0);
    chk(16'(mode), 16'h5);
    run(16'h00A5);
    run(16'h003C);
    chk(16'(r[15:8]), 16'h0052);
    // Direct: strap released after capture must not change the mode.
    pg_cycle(1'h0, 1'h1);
    chk(16'(mode), 16'h6);
    direct_sel <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      led_en <= 4'h1 << i;
      cyc(6);
      chk(16'(leds_n), {12'h000, ~(4'h1 << i)});
    end
    led_en <= 4'h0;
    rst_ctl_n <= 1'h0;
    cyc(6);
    chk(16'(rout_n), 16'h3);
    rst_ctl_n <= 1'h1;
    // Fill the stalled buffer until it refuses, then drain back to back.
    pg_cycle(1'h0, 1'h0);
    cmd_valid <= 1'h1;
    cmd_data <= 16'h1100;
    n = 0;
    repeat (12)
    begin
      @(posedge mclk);
      if (cmd_ready === 1'h1) n++;
      if (cmd_ready === 1'h1) cmd_data <= cmd_data + 16'h1;
    end
    cmd_valid <= 1'h0;
    chk(16'(n), 16'h8);
    direct_sel <= 1'h0;
    n = 0;
    repeat (900)
    begin
      @(posedge mclk);
      if (rsp_valid === 1'h1) n++;
    end
    chk(16'(n), 16'h8);
    chk({b_ctl, a_ctl}, 16'h1107);
    complete_run;
  end
endmodule // hot_plug_slot_serial_ctrl_if_tb
`default_nettype wire
